// ### design/cfdt_pkg.sv
package cfdt_pkg;
  localparam int CLK_PERIOD_NS = 50;

  // Fault classes, one bit each in status, mask and live fields, a four-bit code each in control
  localparam int FAULT_COUNT = 4;
  localparam int IDX_DOC     = 0;
  localparam int IDX_CSC     = 1;
  localparam int IDX_DSC1    = 2;
  localparam int IDX_DSC2    = 3;

  // Delay timing, figures in their own units
  localparam int DOC_BASE_MS      = 1;
  localparam int DOC_STEP_US      = 2 * 1000;
  localparam int DOC_MIN_NS       = DOC_BASE_MS * 1000000;
  localparam int CSC_STEP_US      = 61;
  localparam int DSC1_STEP_US     = 61;
  localparam int DSC1_STEP_X2_US  = 121;
  localparam int DSC2_STEP_NS     = 30500;
  localparam int DSC2_STEP_X2_US  = 61;

  // Derived cycle counts
  localparam int DOC_BASE_CYC     = DOC_MIN_NS / CLK_PERIOD_NS;
  localparam int DOC_STEP_CYC     = DOC_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int CSC_STEP_CYC     = CSC_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int DSC1_STEP_CYC    = DSC1_STEP_US * 1000 / CLK_PERIOD_NS;
  localparam int DSC1_STEP_X2_CYC = DSC1_STEP_X2_US * 1000 / CLK_PERIOD_NS;
  localparam int DSC2_STEP_CYC    = DSC2_STEP_NS / CLK_PERIOD_NS;
  localparam int DSC2_STEP_X2_CYC = DSC2_STEP_X2_US * 1000 / CLK_PERIOD_NS;

  localparam int COUNT_W = 20;
  localparam int CODE_W  = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_THRESHOLD = 8'h04;
  localparam logic [7:0] OFS_STATUS    = 8'h08;
  localparam logic [7:0] OFS_MASK      = 8'h0c;
  localparam logic [7:0] OFS_LIVE      = 8'h10;

  // Control and live field positions
  localparam int CTRL_DOC_LSB    = 0;
  localparam int CTRL_CSC_LSB    = 4;
  localparam int CTRL_DSC1_LSB   = 8;
  localparam int CTRL_DSC2_LSB   = 12;
  localparam int CTRL_DOUBLE_BIT = 16;
  localparam int CTRL_RANGE_BIT  = 17;
  localparam int LIVE_FAULT_LSB  = 4;

  // Reset values
  localparam logic [17:0] CTRL_RESET      = 18'h00000;
  localparam logic [3:0]  THRESHOLD_RESET = 4'h0;
  localparam logic [3:0]  MASK_RESET      = 4'h0;
endpackage

// ### design/cfdt_timer_if.sv
`timescale 1ns/1ps
interface cfdt_timer_if;
  import cfdt_pkg::*;
  logic               cond;
  logic [COUNT_W-1:0] target;
  logic               fault;
  modport ctrl  (output cond, output target, input fault);
  modport timer (input cond, input target, output fault);
endinterface

// ### design/cfdt_sync.sv
`timescale 1ns/1ps
module cfdt_sync
  import cfdt_pkg::*;
#(
  parameter int WIDTH = FAULT_COUNT
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire  [WIDTH-1:0] agree = ~(stage2 ^ stage3);

  // A bit only moves once two late stages agree, rejecting a single-cycle glitch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      sync   <= '0;
    end
    else
    begin
      stage1 <= async;
      stage2 <= stage1;
      stage3 <= stage2;
      sync   <= (agree & stage3) | (~agree & sync);
    end
  end
endmodule

// ### design/cfdt_fault_timer.sv
`timescale 1ns/1ps
module cfdt_fault_timer
  import cfdt_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  cfdt_timer_if.timer port
);
  logic [COUNT_W-1:0] count;
  wire                reached = (count >= port.target);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count      <= '0;
      port.fault <= 1'b0;
    end
    else if (!port.cond)
    begin
      count      <= '0;
      port.fault <= 1'b0;
    end
    else if (reached)
    begin
      port.fault <= 1'b1;
    end
    else
    begin
      count <= count + COUNT_W'(1);
    end
  end
endmodule

// ### design/current_fault_delay_timer.sv
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Functional notes
// - Overcurrent delay 1 to 31 ms, 2 ms steps
// - Charge short delay 0 to 915 us, 61 us
// - First short delay step 61 or 121 us
// - Second short delay step 30.5 or 61 us
// - Fault recognised within 160 us
// - Longest delay within ten percent of setting
// - Overcurrent threshold code, range bit halves it
module current_fault_delay_timer
  import cfdt_pkg::*;
#(
  parameter int DOC_BASE_CYCLES = DOC_BASE_CYC,
  parameter int DOC_STEP_CYCLES = DOC_STEP_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        dischargeOvercurrentCmp,
  input  wire logic        chargeShortCircuitCmp,
  input  wire logic        dischargeShortFirstLevelCmp,
  input  wire logic        dischargeShortSecondLevelCmp,
  output logic             senseRangeSelect,
  output logic [3:0]       dischargeOvercurrentThreshold,
  output logic [3:0]       faultActive,
  output logic             chargeFetOff,
  output logic             dischargeFetOff,
  output logic             irq
);
  function automatic logic [COUNT_W-1:0] delayCycles(input logic [CODE_W-1:0] code,
                                                     input int base, input int step);
    delayCycles = COUNT_W'(base + int'(code) * step);
  endfunction

  logic [17:0]            ctrl;
  logic [3:0]             threshold;
  logic [FAULT_COUNT-1:0] status;
  logic [FAULT_COUNT-1:0] mask;
  logic [FAULT_COUNT-1:0] faultPrev;
  logic                   wrPending;
  logic [7:0]             wrAddr;

  logic [FAULT_COUNT-1:0] condSync;
  logic [FAULT_COUNT-1:0] faultNow;
  wire  [FAULT_COUNT-1:0] condRaw = {dischargeShortSecondLevelCmp, dischargeShortFirstLevelCmp,
                                     chargeShortCircuitCmp, dischargeOvercurrentCmp};

  // Comparators are analog and asynchronous, so they cross a three-stage filter
  cfdt_sync #(.WIDTH(FAULT_COUNT)) condSyncer
  (
    .clk   (clk),
    .rst   (rst),
    .async (condRaw),
    .sync  (condSync)
  );

  wire doubling = ctrl[CTRL_DOUBLE_BIT];
  wire [CODE_W-1:0] codeDoc  = ctrl[CTRL_DOC_LSB +: CODE_W];
  wire [CODE_W-1:0] codeCsc  = ctrl[CTRL_CSC_LSB +: CODE_W];
  wire [CODE_W-1:0] codeDsc1 = ctrl[CTRL_DSC1_LSB +: CODE_W];
  wire [CODE_W-1:0] codeDsc2 = ctrl[CTRL_DSC2_LSB +: CODE_W];

  wire [COUNT_W-1:0] targetDoc  = delayCycles(codeDoc, DOC_BASE_CYCLES, DOC_STEP_CYCLES);
  wire [COUNT_W-1:0] targetCsc  = delayCycles(codeCsc, 0, CSC_STEP_CYC);
  wire [COUNT_W-1:0] targetDsc1 = doubling ? delayCycles(codeDsc1, 0, DSC1_STEP_X2_CYC)
                                           : delayCycles(codeDsc1, 0, DSC1_STEP_CYC);
  wire [COUNT_W-1:0] targetDsc2 = doubling ? delayCycles(codeDsc2, 0, DSC2_STEP_X2_CYC)
                                           : delayCycles(codeDsc2, 0, DSC2_STEP_CYC);
  wire [COUNT_W-1:0] targets [FAULT_COUNT] = '{targetDoc, targetCsc, targetDsc1, targetDsc2};

  // Steps come from exact cycle counts of one clock, so the error is the clock's own
  cfdt_timer_if timerLink [FAULT_COUNT] ();

  genvar i;
  generate
    for (i = 0; i < FAULT_COUNT; i++)
    begin : gTimer
      assign timerLink[i].cond   = condSync[i];
      assign timerLink[i].target = targets[i];
      assign faultNow[i]         = timerLink[i].fault;
      cfdt_fault_timer timer
      (
        .clk  (clk),
        .rst  (rst),
        .port (timerLink[i])
      );
    end
  endgenerate

  // Zero short-circuit code flags four filter cycles plus one count cycle after the edge, far inside 160 us
  wire [FAULT_COUNT-1:0] faultRise = faultNow & ~faultPrev;

  // Bus decode
  wire addrPhase  = hsel & htrans[1] & hready;
  wire [7:0] rdAddr = haddr[7:0];
  wire hitCtrl      = wrPending && (wrAddr == OFS_CTRL);
  wire hitThreshold = wrPending && (wrAddr == OFS_THRESHOLD);
  wire hitStatus    = wrPending && (wrAddr == OFS_STATUS);
  wire hitMask      = wrPending && (wrAddr == OFS_MASK);
  wire [FAULT_COUNT-1:0] statusClear = hitStatus ? hwdata[FAULT_COUNT-1:0] : '0;

  logic [31:0] readMux;
  always_comb
  begin
    if (rdAddr == OFS_CTRL)
      readMux = {14'h0, ctrl};
    else if (rdAddr == OFS_THRESHOLD)
      readMux = {28'h0000000, threshold};
    else if (rdAddr == OFS_STATUS)
      readMux = {28'h0000000, status};
    else if (rdAddr == OFS_MASK)
      readMux = {28'h0000000, mask};
    else if (rdAddr == OFS_LIVE)
      readMux = {24'h000000, faultNow, condSync};
    else
      readMux = 32'h00000000;
  end

  // Zero-wait slave: read data is captured in the address phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
      hrdata    <= 32'h00000000;
    end
    else
    begin
      wrPending <= addrPhase & hwrite;
      wrAddr    <= rdAddr;
      if (addrPhase && !hwrite)
        hrdata <= readMux;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl      <= CTRL_RESET;
      threshold <= THRESHOLD_RESET;
      mask      <= MASK_RESET;
    end
    else
    begin
      if (hitCtrl)
        ctrl <= hwdata[17:0];
      if (hitThreshold)
        threshold <= hwdata[3:0];
      if (hitMask)
        mask <= hwdata[FAULT_COUNT-1:0];
    end
  end

  // A new fault in the cycle of its clear stays set
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status    <= '0;
      faultPrev <= '0;
    end
    else
    begin
      faultPrev <= faultNow;
      status    <= (status & ~statusClear) | faultRise;
    end
  end

  // Analog side scales the threshold step by the range bit
  assign senseRangeSelect              = ctrl[CTRL_RANGE_BIT];
  assign dischargeOvercurrentThreshold = threshold;
  assign faultActive                   = faultNow;
  assign chargeFetOff    = status[IDX_CSC];
  assign dischargeFetOff = status[IDX_DOC] | status[IDX_DSC1] | status[IDX_DSC2];
  assign irq             = |(status & mask);
endmodule

// ### tb/cfdt_asserts.sv
`timescale 1ns/1ps
module cfdt_asserts
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       dischargeOvercurrentCmp,
  input wire logic       chargeShortCircuitCmp,
  input wire logic [3:0] faultActive,
  input wire logic       chargeFetOff,
  input wire logic       dischargeFetOff,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not zero wait okay");
  overcurrent_fet_a: assert property ($rose(faultActive[0]) |=> dischargeFetOff)
    else $error("overcurrent did not stop discharge");
  charge_short_fet_a: assert property ($rose(faultActive[1]) |=> chargeFetOff)
    else $error("charge short did not stop charge");
  first_short_fet_a: assert property ($rose(faultActive[2]) |=> dischargeFetOff)
    else $error("first short did not stop discharge");
  second_short_fet_a: assert property ($rose(faultActive[3]) |=> dischargeFetOff)
    else $error("second short did not stop discharge");
  overcurrent_clear_a: assert property (!dischargeOvercurrentCmp [*8] |-> !faultActive[0])
    else $error("overcurrent fault outlived condition");
  charge_clear_a: assert property (!chargeShortCircuitCmp [*8] |-> !faultActive[1])
    else $error("charge short fault outlived condition");
  irq_source_a: assert property (irq |-> chargeFetOff || dischargeFetOff)
    else $error("irq without latched fault");
  cover property ($rose(faultActive[1]));
  cover property ($rose(irq));
  cover property ($fell(chargeFetOff));
endmodule

bind current_fault_delay_timer cfdt_asserts u_chk (.clk, .rst, .hreadyout, .hresp,
  .dischargeOvercurrentCmp, .chargeShortCircuitCmp, .faultActive, .chargeFetOff,
  .dischargeFetOff, .irq);

// ### tb/cfdt_cmp_model.sv
`timescale 1ns/1ps
module cfdt_cmp_model
(
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [3:0] want,
  output logic      [3:0] cmp
);
  // Slow mode adds a settling cycle, as a weakly overdriven comparator would
  logic [3:0] s1;
  initial s1 = '0;
  initial cmp = '0;
  always @(posedge clk)
  begin
    s1 <= want;
    cmp <= slow ? s1 : want;
  end
endmodule

// ### tb/current_fault_delay_timer_bench.sv
`timescale 1ns/1ps
module current_fault_delay_timer_bench;
  import cfdt_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, rng, irq, cfo, dfo, slow;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  want, cmp, thr, fa;
  int          mismatches, totalChecks, cyc, n;
  current_fault_delay_timer #(.DOC_BASE_CYCLES(20), .DOC_STEP_CYCLES(40)) dut (.clk,
    .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .dischargeOvercurrentCmp(cmp[0]), .chargeShortCircuitCmp(cmp[1]),
    .dischargeShortFirstLevelCmp(cmp[2]), .dischargeShortSecondLevelCmp(cmp[3]),
    .senseRangeSelect(rng), .dischargeOvercurrentThreshold(thr), .faultActive(fa),
    .chargeFetOff(cfo), .dischargeFetOff(dfo), .irq);
  cfdt_cmp_model u_cmp (.clk, .slow, .want, .cmp);
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_win(input int c, input int lo, input int hi);
    totalChecks++;
    if (c < lo || c > hi)
    begin
      mismatches++;
      $display("MISMATCH t=%0t delay %0d not in %0d..%0d", $time, c, lo, hi);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1) @(posedge clk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1) @(posedge clk);
    rd = hrdata;
  endtask
  // Cycle counts at 20 MHz: 61 us is 1220 cycles, overcurrent base and step shortened
  function int dly(int i, int c, logic x);
    case (i)
      0: return 20 + c * 40;
      1: return c * 1220;
      2: return c * (x ? 2420 : 1220);
      default: return c * (x ? 1220 : 610);
    endcase
  endfunction
  task run(input int i, input int c, input logic x, input logic g);
    logic [3:0] m;
    m = 4'($urandom);
    bus(1, OFS_MASK, {28'h0, m});
    v = (32'(x) << 16) | (32'(c) << 4 * i) | (32'($urandom % 2) << 17);
    bus(1, OFS_CTRL, v);
    if (g)
    begin
      want[i] <= 1;
      repeat (dly(i, c, x) / 2) @(posedge clk);
      want[i] <= 0;
      repeat (10) @(posedge clk);
    end
    want[i] <= 1;
    n = 0;
    while (fa[i] !== 1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    chk_win(n, dly(i, c, x), dly(i, c, x) + 12);
    @(posedge clk);
    chk_reg(32'(rng), 32'(v[17]));
    chk_reg(32'(irq), 32'(m[i]));
    chk_reg({30'h0, cfo, dfo}, i == 1 ? 2 : 1);
    bus(0, OFS_LIVE, 0);
    chk_reg(rd, (32'h1 << (LIVE_FAULT_LSB + i)) | (32'h1 << i));
    want[i] <= 0;
    repeat (10) @(posedge clk);
    bus(1, OFS_STATUS, 32'h1 << i);
    bus(0, OFS_STATUS, 0);
    chk_reg(rd | 32'(irq), 0);
    $display("delay test %0d code %0d done", i, c);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      mismatches++;
      final_report();
    end
  end
  task final_report;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {rst, hsel, hwrite, htrans, haddr, hwdata, want, slow} = '1;
    {hsel, hwrite, htrans, haddr, hwdata, want, slow} = '0;
    hsize = 3'h2;
    void'($urandom(32));
    repeat (8) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int k = 0; k < 5; k++)
    begin
      bus(0, k == 4 ? 8'h20 : 8'(k * 4), 32'h5);
      chk_reg(rd, 0);
    end
    v = $urandom;
    bus(1, OFS_THRESHOLD, v);
    bus(0, OFS_THRESHOLD, 0);
    chk_reg({thr, rd[3:0]}, {v[3:0], v[3:0]});
    $display("register test done");
    for (int i = 0; i < 8; i++)
    begin
      slow <= 1'($urandom);
      run(i / 2, 1 + $urandom % 3, 1'(i), 0);
    end
    run(0, 15, 0, 0);
    run(3, 0, 0, 0);
    chk_win(n, 0, 3200);
    run(1, 1, 0, 1);
    run(2, 15, 1, 0);
    chk_win(n, 33300, 40700);
    final_report();
  end
endmodule
